// ### rtl/scmr_config_readout.sv
// Serial configuration memory read-out: counters, paging, cascade, power-up indicator.
// Assumes all pins arrive asynchronously; program write port runs from clk.
`timescale 1ns/1ps
`include "scmr_params.svh"

module scmr_config_readout #(
    parameter int ADDR_W = `SCMR_ADDR_W,
    parameter int BIT_W  = `SCMR_BIT_W
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      chip_select_n,
    input  wire logic                      resetOutEnable,
    input  wire logic                      config_clock,
    input  wire logic                      serial_program_enable_n,
    input  wire logic                      pageEnable,
    input  wire logic [1:0]                page_select,
    input  wire logic                      prog_device_select,
    input  wire logic                      dataIn,
    output logic                           dataOut,
    output logic                           dataOe,
    output logic                           cascade_out_n,
    output logic                           readyOut,
    output logic                           readyOe,
    output logic                           standby,
    input  wire logic                      progWriteEn,
    input  wire logic [ADDR_W+BIT_W-1:0]   progWriteIdx,
    input  wire logic                      progWriteBit,
    output scmr_pkg::scmr_state_t          readoutState
);
    import scmr_pkg::*;

    localparam int MEM_W  = ADDR_W + BIT_W;
    localparam int PAGE_W = ADDR_W - `SCMR_PAGE_SEL_W;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [`SCMR_PIN_W-1:0] pinRaw;
    logic [`SCMR_PIN_W-1:0] pinSync;
    logic                   csN;
    logic                   oeS;
    logic                   cclkS;
    logic                   cfgMode;
    logic                   pageEnS;
    logic [1:0]             pageSelS;
    logic                   progSelS;
    logic                   dataInS;

    assign pinRaw = {dataIn, prog_device_select, page_select, pageEnable,
                     serial_program_enable_n, config_clock, resetOutEnable, chip_select_n};

    scmr_sync3 #(
        .WIDTH   (`SCMR_PIN_W),
        .RST_VAL (`SCMR_PIN_RST)
    ) scmr_sync3_inst (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   (pinRaw),
        .pinOut  (pinSync)
    );

    assign csN      = pinSync[`SCMR_PIN_CSN];
    assign oeS      = pinSync[`SCMR_PIN_OE];
    assign cclkS    = pinSync[`SCMR_PIN_CCLK];
    assign cfgMode  = pinSync[`SCMR_PIN_SEPN];
    assign pageEnS  = pinSync[`SCMR_PIN_PGEN];
    assign pageSelS = pinSync[`SCMR_PIN_PSEL];
    assign progSelS = pinSync[`SCMR_PIN_PDSEL];
    assign dataInS  = pinSync[`SCMR_PIN_DATA];

    ////////////////////////////////////////////////////////////////////////////
    // Storage array

    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [BIT_W-1:0]  bitCnt_reg;
    logic [BIT_W-1:0]  bitCnt_next;
    logic              memBitA;
    logic              memBitB;
    logic              progWrite;

    // Programming writes only reach the array while this device is selected
    assign progWrite = progWriteEn && !cfgMode && progSelS;

    scmr_bit_store #(
        .IDX_W    (MEM_W)
    ) scmr_bit_store_inst (
        .clk      (clk),
        .writeEn  (progWrite),
        .writeIdx (progWriteIdx),
        .writeBit (progWriteBit),
        .readIdxA ({addr_reg, bitCnt_reg}),
        .readBitA (memBitA),
        .readIdxB (progWriteIdx),
        .readBitB (memBitB)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Paging window

    logic [ADDR_W-1:0] pageStart;
    logic [ADDR_W-1:0] pageLast;

    always_comb begin
        if (pageEnS) begin
            pageStart = {pageSelS, {PAGE_W{1'b0}}};
            pageLast  = {pageSelS, {PAGE_W{1'b1}}};
        end else begin
            pageStart = '0;
            pageLast  = '1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-out state and counters

    scmr_state_t state_reg;
    scmr_state_t state_next;
    logic        cclkPrev_reg;
    logic        clkRise;
    logic        step;
    logic        lastBit;

    // Edge taken from the settled level, never from the first stage
    assign clkRise = cclkS && !cclkPrev_reg;
    assign step    = (state_reg == ST_READ) && clkRise && !csN && oeS && cfgMode;
    assign lastBit = (addr_reg == pageLast) && (bitCnt_reg == {BIT_W{1'b1}});

    always_comb begin
        state_next  = state_reg;
        addr_next   = addr_reg;
        bitCnt_next = bitCnt_reg;
        if (!cfgMode) begin
            // Programming mode: chip select and paging pins are ignored
            state_next = ST_PROG;
        end else if (!oeS) begin
            state_next  = ST_IDLE;
            addr_next   = pageStart;
            bitCnt_next = '0;
        end else begin
            unique case (state_reg)
                ST_PROG: begin
                    state_next  = ST_IDLE;
                    addr_next   = pageStart;
                    bitCnt_next = '0;
                end
                ST_IDLE: begin
                    state_next = ST_READ;
                end
                ST_READ: begin
                    if (step) begin
                        if (lastBit) begin
                            state_next = ST_DONE;
                        end else if (bitCnt_reg == {BIT_W{1'b1}}) begin
                            bitCnt_next = '0;
                            addr_next   = ADDR_W'(addr_reg + 1'b1);
                        end else begin
                            bitCnt_next = BIT_W'(bitCnt_reg + 1'b1);
                        end
                    end
                end
                ST_DONE: begin
                    state_next = ST_DONE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin outputs

    logic dataOut_reg;
    logic dataOut_next;
    logic dataOe_reg;
    logic dataOe_next;
    logic casc_reg;
    logic casc_next;
    logic standby_reg;
    logic standby_next;

    always_comb begin
        if (cfgMode) begin
            dataOut_next = memBitA;
            // Driver enabled only while reading, selected and enabled
            dataOe_next  = (state_reg == ST_READ) && oeS && !csN;
        end else begin
            // Open collector: only ever pull low, and only when selected
            dataOut_next = 1'b0;
            dataOe_next  = progSelS && !memBitB;
        end
        casc_next    = (cfgMode && oeS && (state_reg == ST_DONE)) ? csN : 1'b1;
        standby_next = cfgMode && csN;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-up indicator

    logic [`SCMR_POR_CNT_W-1:0] porCnt_reg;
    logic [`SCMR_POR_CNT_W-1:0] porCnt_next;
    logic                       ready_reg;
    logic                       ready_next;

    always_comb begin
        porCnt_next = (porCnt_reg != '0) ? `SCMR_POR_CNT_W'(porCnt_reg - 1'b1) : porCnt_reg;
        ready_next  = (porCnt_reg == '0);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= ST_IDLE;
            addr_reg     <= '0;
            bitCnt_reg   <= '0;
            cclkPrev_reg <= 1'b1;
            dataOut_reg  <= 1'b0;
            dataOe_reg   <= 1'b0;
            casc_reg     <= 1'b1;
            standby_reg  <= 1'b0;
            porCnt_reg   <= `SCMR_POR_CNT_W'(`SCMR_POR_CYCLES);
            ready_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            addr_reg     <= addr_next;
            bitCnt_reg   <= bitCnt_next;
            cclkPrev_reg <= cclkS;
            dataOut_reg  <= dataOut_next;
            dataOe_reg   <= dataOe_next;
            casc_reg     <= casc_next;
            standby_reg  <= standby_next;
            porCnt_reg   <= porCnt_next;
            ready_reg    <= ready_next;
        end
    end

    assign dataOut       = dataOut_reg;
    assign dataOe        = dataOe_reg;
    assign cascade_out_n = casc_reg;
    assign standby       = standby_reg;
    assign readyOut      = 1'b0;
    assign readyOe       = !ready_reg;
    assign readoutState  = state_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_enabled;
        cfgMode && oeS && !csN;
    endsequence

    sequence s_last_step;
        (state_reg == ST_READ) && step && lastBit;
    endsequence

    property p_oe_low_tristate;
        (cfgMode && !oeS) |=> !dataOe_reg;
    endproperty
    a_oe_low_tristate: assert property (p_oe_low_tristate)
        else $error("data driven while output enable low");

    property p_counters_clear;
        (cfgMode && !oeS) |=> (bitCnt_reg == '0) && (addr_reg == $past(pageStart));
    endproperty
    a_counters_clear: assert property (p_counters_clear)
        else $error("counters not cleared to page start");

    property p_cs_high_halt;
        (cfgMode && oeS && csN) |=> $stable(addr_reg) && $stable(bitCnt_reg);
    endproperty
    a_cs_high_halt: assert property (p_cs_high_halt)
        else $error("counters moved with chip select high");

    property p_step_advance;
        (step && !lastBit && (bitCnt_reg != {BIT_W{1'b1}}))
            |=> (bitCnt_reg == BIT_W'($past(bitCnt_reg) + 1'b1)) && $stable(addr_reg);
    endproperty
    a_step_advance: assert property (p_step_advance)
        else $error("bit counter did not advance by one");

    property p_carry;
        (step && !lastBit && (bitCnt_reg == {BIT_W{1'b1}}))
            |=> (bitCnt_reg == '0) && (addr_reg == ADDR_W'($past(addr_reg) + 1'b1));
    endproperty
    a_carry: assert property (p_carry)
        else $error("address counter missed carry");

    property p_end_cascade;
        s_last_step ##1 s_enabled |=> !casc_reg && !dataOe_reg;
    endproperty
    a_end_cascade: assert property (p_end_cascade)
        else $error("end of data not signalled");

    property p_casc_follow;
        (cfgMode && oeS && (state_reg == ST_DONE)) |=> (casc_reg == $past(csN));
    endproperty
    a_casc_follow: assert property (p_casc_follow)
        else $error("cascade does not follow chip select");

    property p_casc_idle_high;
        (state_reg != ST_DONE) |=> casc_reg;
    endproperty
    a_casc_idle_high: assert property (p_casc_idle_high)
        else $error("cascade low before end of data");

    property p_standby;
        (cfgMode && csN) |=> standby_reg && !dataOe_reg;
    endproperty
    a_standby: assert property (p_standby)
        else $error("no standby with chip select high");

    property p_prog_ignores_cs;
        !cfgMode |=> (state_reg == ST_PROG) && $stable(addr_reg) && casc_reg;
    endproperty
    a_prog_ignores_cs: assert property (p_prog_ignores_cs)
        else $error("programming mode disturbed by read-out pins");

    property p_prog_open_collector;
        !cfgMode |=> !dataOut_reg;
    endproperty
    a_prog_open_collector: assert property (p_prog_open_collector)
        else $error("data driven high in programming mode");

    property p_ready_stays;
        !readyOe |=> !readyOe;
    endproperty
    a_ready_stays: assert property (p_ready_stays)
        else $error("ready indicator pulled low again");

    property p_ready_release;
        $fell(sys_rst) |-> readyOe [*8];
    endproperty
    a_ready_release: assert property (p_ready_release)
        else $error("ready released too early");

    property p_power_up_clear;
        $fell(sys_rst) |-> (addr_reg == '0) && (bitCnt_reg == '0);
    endproperty
    a_power_up_clear: assert property (p_power_up_clear)
        else $error("counters not cleared at power-up");

    property p_page_range;
        (cfgMode && pageEnS && (state_reg == ST_READ))
            |-> (addr_reg[ADDR_W-1 -: `SCMR_PAGE_SEL_W] == pageSelS)
                || $changed(pageSelS) || $changed(pageEnS)
                || $past(state_reg != ST_READ);
    endproperty
    a_page_range: assert property (p_page_range)
        else $error("read-out left the selected page");

endmodule

// ### rtl/scmr_params.svh
// Constants of the serial configuration memory read-out block.
// Assumes a single 10 MHz system clock; included by every RTL module file.
`ifndef SCMR_PARAMS_SVH
`define SCMR_PARAMS_SVH

// Array geometry: word address bits and bit-in-word bits (smaller density)
`define SCMR_ADDR_W        18
`define SCMR_BIT_W         4
`define SCMR_PAGE_SEL_W    2

// Clock and power-up reset timing
`define SCMR_CLK_PERIOD_NS 100
`define SCMR_POR_TIME_NS   1000
`define SCMR_POR_CYCLES    ((`SCMR_POR_TIME_NS + `SCMR_CLK_PERIOD_NS - 1) / `SCMR_CLK_PERIOD_NS)
`define SCMR_POR_CNT_W     8

// Pin synchroniser bundle: field positions and idle (pulled) levels
`define SCMR_PIN_W         9
`define SCMR_PIN_CSN       0
`define SCMR_PIN_OE        1
`define SCMR_PIN_CCLK      2
`define SCMR_PIN_SEPN      3
`define SCMR_PIN_PGEN      4
`define SCMR_PIN_PSEL_LO   5
`define SCMR_PIN_PSEL_HI   6
`define SCMR_PIN_PSEL      6:5
`define SCMR_PIN_PDSEL     7
`define SCMR_PIN_DATA      8
`define SCMR_PIN_RST       9'h18F

`endif

// ### rtl/scmr_pkg.sv
// Types shared by the read-out block.
// Assumes nothing beyond the constants header.
package scmr_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_DONE = 4'h4,
        ST_PROG = 4'h8
    } scmr_state_t;

endpackage

// ### rtl/scmr_sync3.sv
// Three-stage synchroniser for a bundle of pin inputs.
// Assumes pins are asynchronous to clk; a change counts once stages two and three agree.
`timescale 1ns/1ps
`include "scmr_params.svh"

module scmr_sync3 #(
    parameter int               WIDTH   = `SCMR_PIN_W,
    parameter logic [WIDTH-1:0] RST_VAL = `SCMR_PIN_RST
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    import scmr_pkg::*;

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            level_next[i] = (stage2_reg[i] == stage3_reg[i]) ? stage3_reg[i] : level_reg[i];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_reg <= RST_VAL;
            stage2_reg <= RST_VAL;
            stage3_reg <= RST_VAL;
            level_reg  <= RST_VAL;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg  <= level_next;
        end
    end

    assign pinOut = level_reg;

endmodule

// ### rtl/scmr_bit_store.sv
// Single-bit storage array, one write port and two read ports.
// Assumes the writer holds index and bit stable while writeEn is high.
`timescale 1ns/1ps
`include "scmr_params.svh"

module scmr_bit_store #(
    parameter int IDX_W = `SCMR_ADDR_W + `SCMR_BIT_W
) (
    input  wire logic             clk,
    input  wire logic             writeEn,
    input  wire logic [IDX_W-1:0] writeIdx,
    input  wire logic             writeBit,
    input  wire logic [IDX_W-1:0] readIdxA,
    output logic                  readBitA,
    input  wire logic [IDX_W-1:0] readIdxB,
    output logic                  readBitB
);
    import scmr_pkg::*;

    // Nonvolatile contents: deliberately never reset
    logic cell_reg [0:(2**IDX_W)-1];

    always_ff @(posedge clk) begin
        if (writeEn) begin
            cell_reg[writeIdx] <= writeBit;
        end
    end

    assign readBitA = cell_reg[readIdxA];
    assign readBitB = cell_reg[readIdxB];

endmodule

// ### dv/scmr_fpga_host.sv
// Master-serial configuring controller facing the read-out block.
// Assumes the bench calls its tasks just after a rising clk edge.
`timescale 1ns/1ps

module scmr_fpga_host (
    input  wire logic       clk,
    input  wire logic       dataOut,
    input  wire logic       dataOe,
    output logic            dataWire,
    output logic            chip_select_n,
    output logic            resetOutEnable,
    output logic            config_clock,
    output logic            serial_program_enable_n,
    output logic            pageEnable,
    output logic [1:0]      page_select
);
    // Seven cycles per phase covers the three-stage pin synchroniser
    localparam int HALF = 7;

    // Pull-up holds the released line high
    assign dataWire = dataOe ? dataOut : 1'b1;

    initial begin
        chip_select_n = 1'b1;
        resetOutEnable = 1'b1;
        config_clock = 1'b0;
        serial_program_enable_n = 1'b1;
        pageEnable = 1'b0;
        page_select = 2'h0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_pins(input logic sen, input logic pe, input logic [1:0] ps,
                            input logic oe, input logic cs);
        wait_clk(1);
        serial_program_enable_n = sen;
        pageEnable = pe;
        page_select = ps;
        resetOutEnable = oe;
        chip_select_n = cs;
        wait_clk(HALF);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Take the presented bit, then one clock period; clock stands low between
    task automatic shift_bit(output logic b, output logic e);
        b = dataWire;
        e = dataOe;
        config_clock = 1'b1;
        wait_clk(HALF);
        config_clock = 1'b0;
        wait_clk(HALF);
    endtask
endmodule

// ### dv/tb_scmr_config_readout.sv
// Self-checking bench for the configuration read-out block.
// Assumes small geometry: 4 address bits, 2 bit-counter bits, 64 stored bits.
`timescale 1ns/1ps

module tb_scmr_config_readout;
    import scmr_pkg::*;
    localparam int AW = 4;
    localparam int BW = 2;
    localparam int NB = 1 << (AW + BW);
    localparam int PB = NB / 4;

    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        pds = 1'b0;
    logic        wEn = 1'b0;
    logic [5:0]  wIdx = 6'h00;
    logic        wBit = 1'b0;
    logic        dataOut, dataOe, casc, readyOut, readyOe, standby, dataWire;
    logic        csN, oe, cclk, senN, pgEn;
    logic [1:0]  pSel;
    scmr_state_t st;
    logic        b, e;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;

    always #50 clk = ~clk;

    scmr_config_readout #(.ADDR_W(AW), .BIT_W(BW)) scmr_config_readout_inst (
        .clk(clk), .sys_rst(sys_rst), .chip_select_n(csN), .resetOutEnable(oe),
        .config_clock(cclk), .serial_program_enable_n(senN), .pageEnable(pgEn),
        .page_select(pSel), .prog_device_select(pds), .dataIn(dataWire),
        .dataOut(dataOut), .dataOe(dataOe), .cascade_out_n(casc), .readyOut(readyOut),
        .readyOe(readyOe), .standby(standby), .progWriteEn(wEn), .progWriteIdx(wIdx),
        .progWriteBit(wBit), .readoutState(st));

    scmr_fpga_host scmr_fpga_host_inst (
        .clk(clk), .dataOut(dataOut), .dataOe(dataOe), .dataWire(dataWire),
        .chip_select_n(csN), .resetOutEnable(oe), .config_clock(cclk),
        .serial_program_enable_n(senN), .pageEnable(pgEn), .page_select(pSel));

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Whole run needs about 2200 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic chk(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    function automatic logic pat(input int i);
        logic [7:0] v;
        v = 8'(i * 29 + 53);
        return v[3] ^ v[6];
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic read_run(input int base, input int n);
        for (int i = 0; i < n; i++) begin
            chk(casc, 1'b1, "cascade early");
            scmr_fpga_host_inst.shift_bit(b, e);
            chk(e, 1'b1, "drive enable");
            chk(b, pat(base + i), "data bit");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        chk(readyOe, 1'b1, "ready in reset");
        chk(casc, 1'b1, "cascade in reset");
        sys_rst = 1'b0;
        tick(9);
        chk(readyOe, 1'b1, "ready hold");
        tick(2);
        chk(readyOe, 1'b0, "ready release");
        chk(readyOut, 1'b0, "ready value");
        // Programming mode, chip select high must not matter
        scmr_fpga_host_inst.set_pins(1'b0, 1'b1, 2'h2, 1'b1, 1'b1);
        pds = 1'b1;
        tick(6);
        chk(standby, 1'b0, "standby in prog");
        wEn = 1'b1;
        for (int i = 0; i < NB; i++) begin
            wIdx = 6'(i);
            wBit = pat(i);
            tick(1);
        end
        wEn = 1'b0;
        pds = 1'b0;
        tick(6);
        wEn = 1'b1;
        wIdx = 6'h00;
        wBit = !pat(0);
        tick(1);
        wEn = 1'b0;
        chk(dataOe, 1'b0, "deselected drive");
        pds = 1'b1;
        tick(6);
        for (int i = 0; i < 8; i++) begin
            wIdx = 6'(i);
            tick(2);
            chk(dataOe, !pat(i), "open drain readback");
            chk(dataOut, 1'b0, "open drain value");
        end
        // Whole part, page select ignored, write refused outside programming
        scmr_fpga_host_inst.set_pins(1'b1, 1'b0, 2'h3, 1'b0, 1'b0);
        wEn = 1'b1;
        wIdx = 6'h01;
        wBit = !pat(1);
        tick(1);
        wEn = 1'b0;
        scmr_fpga_host_inst.set_pins(1'b1, 1'b0, 2'h3, 1'b1, 1'b0);
        read_run(0, NB);
        chk(casc, 1'b0, "cascade at end");
        chk(dataOe, 1'b0, "released at end");
        scmr_fpga_host_inst.set_pins(1'b1, 1'b0, 2'h3, 1'b1, 1'b1);
        chk(casc, 1'b1, "cascade follows high");
        chk(standby, 1'b1, "standby");
        scmr_fpga_host_inst.set_pins(1'b1, 1'b0, 2'h3, 1'b1, 1'b0);
        chk(casc, 1'b0, "cascade follows low");
        scmr_fpga_host_inst.set_pins(1'b1, 1'b0, 2'h3, 1'b0, 1'b0);
        chk(casc, 1'b1, "cascade after reset");
        chk(dataOe, 1'b0, "tri-state in reset");
        // Every page code
        for (int p = 0; p < 4; p++) begin
            scmr_fpga_host_inst.set_pins(1'b1, 1'b1, 2'(p), 1'b0, 1'b0);
            scmr_fpga_host_inst.set_pins(1'b1, 1'b1, 2'(p), 1'b1, 1'b0);
            read_run(p * PB, PB);
            chk(casc, 1'b0, "page end cascade");
            chk(dataOe, 1'b0, "page end release");
        end
        // Chip select and enable in mid-stream
        scmr_fpga_host_inst.set_pins(1'b1, 1'b1, 2'h1, 1'b0, 1'b0);
        scmr_fpga_host_inst.set_pins(1'b1, 1'b1, 2'h1, 1'b1, 1'b0);
        read_run(PB, 5);
        scmr_fpga_host_inst.set_pins(1'b1, 1'b1, 2'h1, 1'b1, 1'b1);
        chk(dataOe, 1'b0, "deselected");
        chk(standby, 1'b1, "standby mid");
        scmr_fpga_host_inst.shift_bit(b, e);
        chk(e, 1'b0, "ignored clock");
        scmr_fpga_host_inst.set_pins(1'b1, 1'b1, 2'h1, 1'b1, 1'b0);
        read_run(PB + 5, 3);
        scmr_fpga_host_inst.set_pins(1'b1, 1'b1, 2'h1, 1'b0, 1'b1);
        chk(dataOe, 1'b0, "reset with select high");
        scmr_fpga_host_inst.set_pins(1'b1, 1'b1, 2'h1, 1'b1, 1'b0);
        read_run(PB, 2);
        final_report();
    end
endmodule
